/* File: common/dpc_pkg.sv */
// constants, register map and state type of the dual converter pin control block
// assumes a single 100 MHz core clock domain and a 32-bit AHB-Lite register bus
package dpc_pkg;

    // three-level strap pins: bit 1 set means floating or mid-supply, bit 0 is the logic level
    localparam logic [1:0] DPC_LVL_LOW = 2'h0;
    localparam logic [1:0] DPC_LVL_HIGH = 2'h1;
    localparam logic [1:0] DPC_LVL_MID = 2'h2;

    // positions in the synchronised pin vector
    localparam int DPC_PIN_FPD = 0;
    localparam int DPC_PIN_QPD = 1;
    localparam int DPC_PIN_CAL = 2;
    localparam int DPC_PIN_RSTP = 3;
    localparam int DPC_PIN_RSTDIFF = 4;
    localparam int DPC_PIN_AMP = 5;
    localparam int DPC_PIN_EDGE = 6;
    localparam int DPC_PIN_DLY = 8;
    localparam int DPC_PIN_FSR = 10;
    localparam int DPC_PIN_W = 12;

    // calibration pin low and high minimum lengths, input clock cycles
    localparam logic [10:0] DPC_CAL_LOW_CYCLES = 11'h500;
    localparam logic [10:0] DPC_CAL_HIGH_CYCLES = 11'h500;
    // cycles after reset release before straps are trusted
    localparam logic [19:0] DPC_STRAP_SETTLE = 20'h00002;

    // register byte offsets
    localparam logic [7:0] DPC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] DPC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] DPC_ADDR_SERIAL = 8'h08;

    // control register fields and reset value
    localparam int DPC_CTRL_DEMUX = 0;
    localparam int DPC_CTRL_EDGE = 1;
    localparam int DPC_CTRL_DDR = 2;
    localparam int DPC_CTRL_DES = 3;
    localparam logic [31:0] DPC_CTRL_MASK = 32'h0000000f;
    localparam logic [31:0] DPC_CTRL_RESET = 32'h00000000;

    // status register fields
    localparam int DPC_ST_EXT = 0;
    localparam int DPC_ST_FPD = 1;
    localparam int DPC_ST_QPD = 2;
    localparam int DPC_ST_CALIB = 3;
    localparam int DPC_ST_DDR = 4;
    localparam int DPC_ST_EDGE = 5;
    localparam int DPC_ST_DES = 6;
    localparam int DPC_ST_DEMUX = 7;
    localparam int DPC_ST_AMP = 8;
    localparam int DPC_ST_FSR = 9;
    localparam int DPC_ST_RSTDIFF = 10;

    localparam logic [1:0] DPC_HTRANS_NONSEQ = 2'h2;
    localparam logic DPC_HRESP_OKAY = 1'h0;

    typedef enum logic [1:0] {
        DPC_CAL_STRAP,
        DPC_CAL_DELAY,
        DPC_CAL_IDLE,
        DPC_CAL_RUN
    } dpc_cal_state_t;

endpackage

/* File: common/dpc_buf_if.sv */
// valid/ready handshake between the demux stage and the output stage buffer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface dpc_buf_if #(parameter int W = 32);
    logic flush;
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport store (input flush, input in_valid, output in_ready, input in_data,
                   output out_valid, input out_ready, output out_data);
    modport user (output flush, output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
endinterface
`default_nettype wire

/* File: verilog/dpc_buffer.sv */
// small flip-flop buffer with valid and ready on both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module dpc_buffer #(
    parameter int W = 32,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // both handshake sides
    dpc_buf_if.store bif
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign bif.in_ready = (count != (PW+1)'(DEPTH));
    assign bif.out_valid = (count != '0);
    assign bif.out_data = mem[rd_ptr];
    assign push = bif.in_valid && bif.in_ready;
    assign pop = bif.out_valid && bif.out_ready;

    // pointers and fill level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (bif.flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (push && !bif.flush) begin
            mem[wr_ptr] <= bif.in_data;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/dpc_pin_control.sv */
// pin control, calibration trigger and output formatting of a dual 8-bit converter
// assumes converter core samples arrive on CORE_CLK; pins and serial clock are asynchronous
// Contract
// - each sample leaves as an 8-bit offset-binary word
// - each converter lane has its own demux feeding two output buses
// - in 1:2 mode consecutive samples alternate buses, each at half rate
// - in 1:1 mode both lanes update at the full sample rate
// - interleaved use makes both lanes carry one stream at twice rate
// - full power-down high stops the whole device; low restores it
// - quadrature power-down high stops only the quadrature lane, except in interleaved use where that lane keeps carrying samples
// - calibration starts after 1280 cycles low then 1280 cycles high
// - a positive pulse on the sync reset input resets output clocks
// - differential sync reset uses this input as the positive half
// - edge select chooses which output clock edge moves the data
// - edge select floating or mid-supply gives double-data-rate output
// - in extended mode the amplitude pin becomes the serial clock
// - in extended mode the edge pin becomes the serial data input
// - range pin floating enters extended mode; registers then govern modes
// - calibration delay pin at logic level picks power-up calibration delay
// - calibration delay pin floating selects dual-edge sampling of one input
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_control import dpc_pkg::*; #(
    parameter int SAMPLE_W = 8,
    parameter int BUF_DEPTH = 2,
    parameter int SERIAL_BITS = 16,
    parameter int CAL_DLY_SHORT = 4096,
    parameter int CAL_DLY_LONG = 65536,
    parameter int CAL_RUN_CYCLES = 4096
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // ahb-lite register slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // control and strap pins, three-level ones as {mid, level}
    input wire logic FULL_POWER_DOWN,
    input wire logic QUAD_POWER_DOWN,
    input wire logic CALIBRATE,
    input wire logic OUT_CLOCK_SYNC_RESET,
    input wire logic OUT_CLOCK_RESET_DIFF,
    input wire logic OUTPUT_AMPLITUDE_SELECT,
    input wire logic [1:0] OUTPUT_EDGE_SELECT,
    input wire logic [1:0] CALIBRATION_DELAY_SELECT,
    input wire logic [1:0] FULL_SCALE_RANGE_SELECT,
    // converter core samples, two's complement
    input wire logic SAMPLE_VALID,
    input wire logic [SAMPLE_W-1:0] SAMPLE_I,
    input wire logic [SAMPLE_W-1:0] SAMPLE_I_LATE,
    input wire logic [SAMPLE_W-1:0] SAMPLE_Q,
    output logic SAMPLE_READY,
    // output buses
    output logic [SAMPLE_W-1:0] INPHASE_OUT_BUS_A,
    output logic [SAMPLE_W-1:0] INPHASE_OUT_BUS_B,
    output logic [SAMPLE_W-1:0] QUAD_OUT_BUS_A,
    output logic [SAMPLE_W-1:0] QUAD_OUT_BUS_B,
    output logic OUT_WORD_VALID,
    input wire logic OUT_READY,
    output logic OUTPUT_DATA_CLOCK,
    // device state
    output logic DEVICE_POWERED_DOWN,
    output logic CALIBRATING
);
    localparam int WW = 4 * SAMPLE_W;
    localparam int CNT_W = 20;
    localparam int SC_W = $clog2(SERIAL_BITS + 1);

    logic [DPC_PIN_W-1:0] pin_raw;
    logic [DPC_PIN_W-1:0] pin_s1;
    logic [DPC_PIN_W-1:0] pin_s2;
    logic sclk_s3;
    logic [1:0] edge_lvl;
    logic [1:0] dly_lvl;
    logic [1:0] fsr_lvl;
    logic diff_sel;
    logic osync;
    logic ext_now;

    logic [31:0] ctrl;
    logic ext_m;
    logic fpd_m;
    logic qpd_m;
    logic ddr_m;
    logic edge_m;
    logic des_m;
    logic demux_m;
    logic running;

    dpc_cal_state_t cal_state;
    logic [CNT_W-1:0] cal_cnt;
    logic dly_long;
    logic [10:0] low_cnt;
    logic [10:0] high_cnt;
    logic armed;
    logic cal_trigger;

    logic [SERIAL_BITS-1:0] shift;
    logic [SC_W-1:0] bit_cnt;
    logic [SERIAL_BITS-1:0] serial_word;
    logic sclk_rise;
    logic cs_active;

    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_req;
    logic [31:0] status;
    logic [31:0] rd_val;

    logic phase;
    logic [2*SAMPLE_W-1:0] hold;
    logic pend_valid;
    logic [WW-1:0] pend_word;
    logic next_phase;
    logic [2*SAMPLE_W-1:0] next_hold;
    logic next_pend_valid;
    logic [WW-1:0] next_pend_word;
    logic [SAMPLE_W-1:0] code_i;
    logic [SAMPLE_W-1:0] code_q;
    logic accept;
    logic pop;
    logic lead_in;

    dpc_buf_if #(.W(WW)) bif ();

    dpc_buffer #(.W(WW), .DEPTH(BUF_DEPTH)) u_buf (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .bif(bif)
    );

    assign pin_raw = {FULL_SCALE_RANGE_SELECT, CALIBRATION_DELAY_SELECT, OUTPUT_EDGE_SELECT,
                      OUTPUT_AMPLITUDE_SELECT, OUT_CLOCK_RESET_DIFF, OUT_CLOCK_SYNC_RESET,
                      CALIBRATE, QUAD_POWER_DOWN, FULL_POWER_DOWN};

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            sclk_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            sclk_s3 <= pin_s2[DPC_PIN_AMP];
        end
    end

    assign edge_lvl = pin_s2[DPC_PIN_EDGE +: 2];
    assign dly_lvl = pin_s2[DPC_PIN_DLY +: 2];
    assign fsr_lvl = pin_s2[DPC_PIN_FSR +: 2];
    assign diff_sel = pin_s2[DPC_PIN_RSTDIFF];
    // range pin mid enters extended mode unless it is the negative reset half
    assign ext_now = !diff_sel && (fsr_lvl == DPC_LVL_MID);
    // single-ended pulse; differential pair, range pin as negative half
    assign osync = diff_sel ? (pin_s2[DPC_PIN_RSTP] && (fsr_lvl == DPC_LVL_LOW)) : pin_s2[DPC_PIN_RSTP];

    // mode decode held in flops so modes change cleanly
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ext_m <= 1'b0;
            fpd_m <= 1'b0;
            qpd_m <= 1'b0;
            ddr_m <= 1'b0;
            edge_m <= 1'b0;
            des_m <= 1'b0;
            demux_m <= 1'b0;
        end else begin
            ext_m <= ext_now;
            fpd_m <= pin_s2[DPC_PIN_FPD];
            qpd_m <= pin_s2[DPC_PIN_QPD];
            demux_m <= ctrl[DPC_CTRL_DEMUX];
            if (ext_now) begin
                ddr_m <= ctrl[DPC_CTRL_DDR];
                edge_m <= ctrl[DPC_CTRL_EDGE];
                des_m <= ctrl[DPC_CTRL_DES];
            end else begin
                ddr_m <= (edge_lvl == DPC_LVL_MID);
                edge_m <= edge_lvl[0];
                // floating delay pin selects dual-edge sampling
                des_m <= (dly_lvl == DPC_LVL_MID);
            end
        end
    end

    assign running = !fpd_m && (cal_state == DPC_CAL_IDLE);

    // calibration pin low then high watcher
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            low_cnt <= '0;
            high_cnt <= '0;
            armed <= 1'b0;
            cal_trigger <= 1'b0;
        end else begin
            cal_trigger <= 1'b0;
            if (!pin_s2[DPC_PIN_CAL]) begin
                high_cnt <= '0;
                if (low_cnt != DPC_CAL_LOW_CYCLES) begin
                    low_cnt <= low_cnt + 11'h001;
                end
                if (low_cnt == DPC_CAL_LOW_CYCLES - 11'h001) begin
                    armed <= 1'b1;
                end
            end else begin
                low_cnt <= '0;
                if (armed) begin
                    if (high_cnt == DPC_CAL_HIGH_CYCLES - 11'h001) begin
                        cal_trigger <= 1'b1;
                        armed <= 1'b0;
                        high_cnt <= '0;
                    end else begin
                        high_cnt <= high_cnt + 11'h001;
                    end
                end
            end
        end
    end

    // power-up delay, calibration run and on-command calibration
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cal_state <= DPC_CAL_STRAP;
            cal_cnt <= '0;
            dly_long <= 1'b0;
        end else begin
            case (cal_state)
                DPC_CAL_STRAP: begin
                    cal_cnt <= cal_cnt + 1'b1;
                    if (cal_cnt == DPC_STRAP_SETTLE) begin
                        // logic level picks the delay; extended mode forces short
                        dly_long <= !ext_now && (dly_lvl == DPC_LVL_HIGH);
                        cal_cnt <= '0;
                        cal_state <= DPC_CAL_DELAY;
                    end
                end
                DPC_CAL_DELAY: begin
                    cal_cnt <= cal_cnt + 1'b1;
                    if (cal_cnt == (dly_long ? CNT_W'(CAL_DLY_LONG - 1) : CNT_W'(CAL_DLY_SHORT - 1))) begin
                        cal_cnt <= '0;
                        cal_state <= DPC_CAL_RUN;
                    end
                end
                DPC_CAL_IDLE: begin
                    if (cal_trigger && !fpd_m) begin
                        cal_cnt <= '0;
                        cal_state <= DPC_CAL_RUN;
                    end
                end
                DPC_CAL_RUN: begin
                    cal_cnt <= cal_cnt + 1'b1;
                    if (cal_cnt == CNT_W'(CAL_RUN_CYCLES - 1)) begin
                        cal_cnt <= '0;
                        cal_state <= DPC_CAL_IDLE;
                    end
                end
                default: begin
                    cal_state <= DPC_CAL_IDLE;
                end
            endcase
        end
    end

    // amplitude pin is serial clock in extended mode
    assign sclk_rise = ext_m && pin_s2[DPC_PIN_AMP] && !sclk_s3;
    assign cs_active = ext_m && (dly_lvl == DPC_LVL_LOW);

    // serial frame capture
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            shift <= '0;
            bit_cnt <= '0;
            serial_word <= '0;
        end else if (cs_active) begin
            if (sclk_rise && bit_cnt != SC_W'(SERIAL_BITS)) begin
                shift <= {shift[SERIAL_BITS-2:0], edge_lvl[0]};
                bit_cnt <= bit_cnt + 1'b1;
            end
        end else begin
            if (bit_cnt == SC_W'(SERIAL_BITS)) begin
                serial_word <= shift;
            end
            bit_cnt <= '0;
        end
    end

    // offset binary by inverting the sign bit
    assign code_i = {~SAMPLE_I[SAMPLE_W-1], SAMPLE_I[SAMPLE_W-2:0]};
    always_comb begin
        if (des_m) begin
            // interleaved: quadrature lane carries the late inphase sample
            code_q = {~SAMPLE_I_LATE[SAMPLE_W-1], SAMPLE_I_LATE[SAMPLE_W-2:0]};
        end else if (qpd_m) begin
            code_q = '0;
        end else begin
            code_q = {~SAMPLE_Q[SAMPLE_W-1], SAMPLE_Q[SAMPLE_W-2:0]};
        end
    end

    assign accept = SAMPLE_VALID && SAMPLE_READY;

    // per-lane demux; word is {i_a, i_b, q_a, q_b}
    always_comb begin
        next_phase = phase;
        next_hold = hold;
        next_pend_valid = pend_valid && !bif.in_ready;
        next_pend_word = pend_word;
        if (accept) begin
            if (!demux_m) begin
                next_pend_valid = 1'b1;
                next_pend_word = {code_i, pend_word[2*SAMPLE_W +: SAMPLE_W], code_q, pend_word[0 +: SAMPLE_W]};
            end else if (!phase) begin
                next_hold = {code_i, code_q};
                next_phase = 1'b1;
            end else begin
                // second sample to bus b, one word per two samples
                next_pend_valid = 1'b1;
                next_pend_word = {hold[SAMPLE_W +: SAMPLE_W], code_i, hold[0 +: SAMPLE_W], code_q};
                next_phase = 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            phase <= 1'b0;
            hold <= '0;
            pend_valid <= 1'b0;
            pend_word <= '0;
            SAMPLE_READY <= 1'b0;
        end else if (osync) begin
            phase <= 1'b0;
            pend_valid <= 1'b0;
            SAMPLE_READY <= 1'b0;
        end else begin
            phase <= next_phase;
            hold <= next_hold;
            pend_valid <= next_pend_valid;
            pend_word <= next_pend_word;
            // no samples taken while powered down or calibrating
            SAMPLE_READY <= running && !next_pend_valid;
        end
    end

    assign bif.flush = osync;
    assign bif.in_valid = pend_valid;
    assign bif.in_data = pend_word;

    // sdr pops only when the clock can move onto the chosen edge
    assign pop = bif.out_valid && OUT_READY && !fpd_m && !osync && (ddr_m || (OUTPUT_DATA_CLOCK != edge_m));
    assign lead_in = bif.out_valid && OUT_READY && !fpd_m && !osync && !ddr_m && (OUTPUT_DATA_CLOCK == edge_m);
    assign bif.out_ready = pop;

    // output stage and output data clock
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            INPHASE_OUT_BUS_A <= '0;
            INPHASE_OUT_BUS_B <= '0;
            QUAD_OUT_BUS_A <= '0;
            QUAD_OUT_BUS_B <= '0;
            OUT_WORD_VALID <= 1'b0;
            OUTPUT_DATA_CLOCK <= 1'b0;
        end else begin
            OUT_WORD_VALID <= pop;
            if (osync || fpd_m) begin
                // sync pulse holds the output clock low
                OUTPUT_DATA_CLOCK <= 1'b0;
            end else if (pop) begin
                {INPHASE_OUT_BUS_A, INPHASE_OUT_BUS_B, QUAD_OUT_BUS_A, QUAD_OUT_BUS_B} <= bif.out_data;
                OUTPUT_DATA_CLOCK <= ddr_m ? !OUTPUT_DATA_CLOCK : edge_m;
            end else if (lead_in) begin
                OUTPUT_DATA_CLOCK <= !OUTPUT_DATA_CLOCK;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            DEVICE_POWERED_DOWN <= 1'b0;
            CALIBRATING <= 1'b0;
        end else begin
            DEVICE_POWERED_DOWN <= fpd_m;
            CALIBRATING <= (cal_state == DPC_CAL_RUN);
        end
    end

    always_comb begin
        status = '0;
        status[DPC_ST_EXT] = ext_m;
        status[DPC_ST_FPD] = fpd_m;
        status[DPC_ST_QPD] = qpd_m;
        status[DPC_ST_CALIB] = (cal_state != DPC_CAL_IDLE);
        status[DPC_ST_DDR] = ddr_m;
        status[DPC_ST_EDGE] = edge_m;
        status[DPC_ST_DES] = des_m;
        status[DPC_ST_DEMUX] = demux_m;
        status[DPC_ST_AMP] = pin_s2[DPC_PIN_AMP] && !ext_m;
        status[DPC_ST_FSR] = diff_sel || fsr_lvl[0];
        status[DPC_ST_RSTDIFF] = diff_sel;
    end

    always_comb begin
        case (HADDR[7:0])
            DPC_ADDR_CTRL: rd_val = (wr_pend && wr_addr == DPC_ADDR_CTRL) ? (HWDATA & DPC_CTRL_MASK) : ctrl;
            DPC_ADDR_STATUS: rd_val = status;
            DPC_ADDR_SERIAL: rd_val = 32'(serial_word);
            default: rd_val = '0;
        endcase
    end

    assign rd_req = HSEL && HREADY && (HTRANS == DPC_HTRANS_NONSEQ) && !HWRITE && (HADDR[31:8] == '0);

    // ahb-lite address phase and read data
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            HRDATA <= '0;
            HREADYOUT <= 1'b1;
            HRESP <= DPC_HRESP_OKAY;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= DPC_HRESP_OKAY;
            if (HREADY) begin
                wr_pend <= HSEL && (HTRANS == DPC_HTRANS_NONSEQ) && HWRITE && (HADDR[31:8] == '0);
                wr_addr <= HADDR[7:0];
                HRDATA <= rd_req ? rd_val : '0;
            end
        end
    end

    // control register write in data phase
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl <= DPC_CTRL_RESET;
        end else if (wr_pend && wr_addr == DPC_ADDR_CTRL) begin
            ctrl <= HWDATA & DPC_CTRL_MASK;
        end
    end
endmodule
`default_nettype wire

/* File: dv/dpc_pin_control_assertions.sv */
// port checker of the pin control block
// assumes it is bound onto dpc_pin_control
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_control_assertions (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // pins
    input wire logic FULL_POWER_DOWN,
    input wire logic QUAD_POWER_DOWN,
    input wire logic OUT_CLOCK_SYNC_RESET,
    input wire logic OUT_CLOCK_RESET_DIFF,
    input wire logic [1:0] OUTPUT_EDGE_SELECT,
    // outputs
    input wire logic SAMPLE_READY,
    input wire logic OUT_WORD_VALID,
    input wire logic OUTPUT_DATA_CLOCK,
    input wire logic DEVICE_POWERED_DOWN,
    input wire logic CALIBRATING
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    a_fpd_enter: assert property (FULL_POWER_DOWN [*5] |-> DEVICE_POWERED_DOWN)
        else $error("not down");
    a_fpd_leave: assert property (!FULL_POWER_DOWN [*5] |-> !DEVICE_POWERED_DOWN)
        else $error("still down");
    a_quad_only: assert property ((QUAD_POWER_DOWN && !FULL_POWER_DOWN) [*5] |-> !DEVICE_POWERED_DOWN)
        else $error("quad stops all");
    a_down_no_take: assert property (DEVICE_POWERED_DOWN [*2] |-> !SAMPLE_READY)
        else $error("ready in down");
    a_cal_no_take: assert property (CALIBRATING [*2] |-> !SAMPLE_READY)
        else $error("ready in cal");
    a_sync_quiet: assert property ((OUT_CLOCK_SYNC_RESET && !OUT_CLOCK_RESET_DIFF) [*5]
        |-> !OUTPUT_DATA_CLOCK && !OUT_WORD_VALID) else $error("clock in sync");
    a_word_toggle: assert property (OUT_WORD_VALID |-> OUTPUT_DATA_CLOCK != $past(OUTPUT_DATA_CLOCK))
        else $error("word no edge");
    a_rise_edge: assert property ((OUTPUT_EDGE_SELECT == 2'h1) [*5] ##0 OUT_WORD_VALID |-> OUTPUT_DATA_CLOCK)
        else $error("word not rising");
endmodule
bind dpc_pin_control dpc_pin_control_assertions dpc_pin_control_assertions_i (.CORE_CLK, .SYS_RST,
    .FULL_POWER_DOWN, .QUAD_POWER_DOWN, .OUT_CLOCK_SYNC_RESET, .OUT_CLOCK_RESET_DIFF, .OUTPUT_EDGE_SELECT,
    .SAMPLE_READY, .OUT_WORD_VALID, .OUTPUT_DATA_CLOCK, .DEVICE_POWERED_DOWN, .CALIBRATING);
`default_nettype wire

/* File: dv/dpc_capture_model.sv */
// capture model: ready stalls three cycles in eight
// assumes the core clock and active-high reset
`timescale 1ns/1ps
`default_nettype none
module dpc_capture_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // word handshake
    output logic ready
);
    logic [2:0] phase;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 3'h0;
            ready <= 1'b0;
        end else begin
            phase <= phase + 3'h1;
            ready <= phase < 3'h5;
        end
    end
endmodule
`default_nettype wire

/* File: dv/dpc_pin_control_bench.sv */
// bench of the pin control block
// assumes the capture model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_control_bench import dpc_pkg::*; ();
    logic CORE_CLK = 0, SYS_RST = 1, HWRITE = 0, FULL_POWER_DOWN = 0, QUAD_POWER_DOWN = 0, CALIBRATE = 0;
    logic OUT_CLOCK_SYNC_RESET = 0, OUTPUT_AMPLITUDE_SELECT = 0, SAMPLE_VALID = 0, OUT_READY, HREADYOUT, HRESP;
    logic OUT_CLOCK_RESET_DIFF = 0;
    logic [1:0] HTRANS = 0, OUTPUT_EDGE_SELECT = 1, CALIBRATION_DELAY_SELECT = 1, FULL_SCALE_RANGE_SELECT = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd, sv, seed = 66288;
    logic [7:0] SAMPLE_I = 0, SAMPLE_I_LATE = 0, SAMPLE_Q = 0, first;
    logic [7:0] INPHASE_OUT_BUS_A, INPHASE_OUT_BUS_B, QUAD_OUT_BUS_A, QUAD_OUT_BUS_B;
    logic SAMPLE_READY, OUT_WORD_VALID, OUTPUT_DATA_CLOCK, DEVICE_POWERED_DOWN, CALIBRATING, demux = 0, half = 0;
    logic [15:0] expq[$];
    int err_total = 0, n_checks = 0;
    dpc_pin_control #(.CAL_DLY_SHORT(16), .CAL_DLY_LONG(64), .CAL_RUN_CYCLES(32)) dpc_pin_control_i (
        .HSEL(1'b1), .HSIZE(3'h2), .HREADY(HREADYOUT), .*);
    dpc_capture_model dpc_capture_model_i (.clk(CORE_CLK), .rst(SYS_RST), .ready(OUT_READY));
    always #5 CORE_CLK = ~CORE_CLK;
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] ob(input logic [7:0] s);
        return s ^ 8'h80;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        HTRANS <= DPC_HTRANS_NONSEQ;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // expected words from taken samples
    always @(posedge CORE_CLK) begin
        if (SAMPLE_VALID && SAMPLE_READY) begin
            if (!demux) expq.push_back({ob(SAMPLE_I), ob(SAMPLE_Q)});
            else if (half) expq.push_back({first, ob(SAMPLE_I)});
            else first = ob(SAMPLE_I);
            if (demux) half = !half;
        end
        if (OUT_WORD_VALID) chk(demux ? {INPHASE_OUT_BUS_A, INPHASE_OUT_BUS_B} : {INPHASE_OUT_BUS_A, QUAD_OUT_BUS_A},
            expq.pop_front());
    end
    initial begin
        repeat (5) @(posedge CORE_CLK);
        SYS_RST <= 0;
        ahb(0, 8'h0c, 0, rd);
        chk(rd, 0);
        for (int p = 0; p < 3; p++) begin
            OUTPUT_EDGE_SELECT <= p[1:0];
            ahb(1, DPC_ADDR_CTRL, 32'(p / 2), rd);
            ahb(0, DPC_ADDR_CTRL, 0, rd);
            chk(rd, 32'(p / 2));
            demux = (p == 2);
            repeat (800) begin
                @(posedge CORE_CLK);
                {SAMPLE_I, SAMPLE_Q, SAMPLE_I_LATE, SAMPLE_VALID} <= 25'(xs());
            end
            SAMPLE_VALID <= 0;
            for (int k = 0; k < 100 && expq.size() > 0; k++) @(posedge CORE_CLK);
            chk(expq.size(), 0);
        end
        OUT_CLOCK_SYNC_RESET <= 1;
        repeat (8) @(posedge CORE_CLK);
        OUT_CLOCK_RESET_DIFF <= 1;
        repeat (8) @(posedge CORE_CLK);
        chk(SAMPLE_READY, 0);
        {OUT_CLOCK_RESET_DIFF, OUT_CLOCK_SYNC_RESET} <= 0;
        FULL_POWER_DOWN <= 1;
        repeat (8) @(posedge CORE_CLK);
        chk(DEVICE_POWERED_DOWN, 1);
        FULL_POWER_DOWN <= 0;
        QUAD_POWER_DOWN <= 1;
        repeat (1300) @(posedge CORE_CLK);
        chk(DEVICE_POWERED_DOWN, 0);
        CALIBRATE <= 1;
        repeat (1270) @(posedge CORE_CLK);
        chk(CALIBRATING, 0);
        repeat (20) @(posedge CORE_CLK);
        chk(CALIBRATING, 1);
        CALIBRATE <= 0;
        QUAD_POWER_DOWN <= 0;
        sv = xs();
        FULL_SCALE_RANGE_SELECT <= 2'h2;
        CALIBRATION_DELAY_SELECT <= 2'h0;
        #0.4;
        for (int i = 15; i >= 0; i--) begin
            #31.2 OUTPUT_EDGE_SELECT = {1'b0, sv[i]};
            #31.3 OUTPUT_AMPLITUDE_SELECT = 1;
            #62.5 OUTPUT_AMPLITUDE_SELECT = 0;
        end
        @(posedge CORE_CLK);
        CALIBRATION_DELAY_SELECT <= 2'h1;
        repeat (10) @(posedge CORE_CLK);
        ahb(0, DPC_ADDR_SERIAL, 0, rd);
        chk(rd, {16'h0, sv[15:0]});
        ahb(0, DPC_ADDR_STATUS, 0, rd);
        chk(rd[DPC_ST_EXT], 1);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
